// ---- sbs_map.svh ----
// Purpose: named offsets, codes, reset values and timing counts of the sensor bus node
// Assumes: ref_clk at 100 MHz
// Notes: times keep their own unit, cycle counts derive from them
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
// clock and timing
`define SBS_CLK_MHZ 100
`define SBS_TO_US 2000
`define SBS_TO_CYC (`SBS_TO_US * `SBS_CLK_MHZ)
`define SBS_UVM_NS 1000
`define SBS_UVM_CYC (`SBS_UVM_NS * `SBS_CLK_MHZ / 1000)
`define SBS_CNT_MAX 12'hFFF
// register offsets and bus answers
`define SBS_OFS_CTRL 8'h00
`define SBS_OFS_STAT 8'h04
`define SBS_OFS_LAST 8'h08
`define SBS_CTRL_RST 2'h3
`define SBS_RESP_OK 2'h0
`define SBS_RESP_ERR 2'h2
// word format and checksum
`define SBS_CRC_SEED 4'hA
`define SBS_LEN_SHORT 5'h0C
`define SBS_LEN_LONG 5'h14
`define SBS_BITS_MAX 5'h1F
// conversion codes
`define SBS_ADC_LO 10'h020
`define SBS_ADC_HI 10'h3E3
`define SBS_ADC_ERR 10'h3F8
// command codes
`define SBS_CMD_INIT 4'h1
`define SBS_CMD_CLEAR 4'h2
`define SBS_CMD_PINCTL 4'h3
`define SBS_CMD_RDPIN 4'h4
`define SBS_CMD_REQ0 4'h5
`define SBS_CMD_REQ1 4'h6
`define SBS_CMD_TEST 4'hF
// dither generator
`define SBS_LFSR_SEED 16'hACE1
`define SBS_LFSR_TAPS 16'hB400
`endif

// ---- sbs_pkg.sv ----
// Purpose: types shared by the sensor bus node files
// Assumes: nothing beyond SystemVerilog packages
// Notes: bus and converter signals travel as packed structs
package sbs_pkg;
    // receiver states
    typedef enum logic [1:0] {rx_idle, rx_wait, rx_blo, rx_bhi} sbs_rx_e;
    // register bus, master to node
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } sbs_axi_req_s;
    // register bus, node to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbs_axi_rsp_s;
    // converter start and result
    typedef struct packed {
        logic start;
        logic chan;
    } sbs_adc_req_s;
    typedef struct packed {
        logic done;
        logic err;
        logic [9:0] code;
    } sbs_adc_rsp_s;
    // whole node state
    typedef struct packed {
        sbs_rx_e rx;
        logic sg_prev;
        logic [11:0] lo_cnt;
        logic [11:0] hi_cnt;
        logic [4:0] bitcnt;
        logic [19:0] sh;
        logic [19:0] tx;
        logic tx_v;
        logic resp_on;
        logic [19:0] pend;
        logic pend_v;
        logic inited;
        logic [3:0] addr;
        logic sw;
        logic [2:0] dir;
        logic [2:0] oval;
        logic test;
        logic [17:0] to_cnt;
        logic [7:0] uv_cnt;
        logic [15:0] lfsr;
        logic dith;
        logic adc_start;
        logic adc_chan;
        logic adc_wait;
        logic [1:0] ctrl;
        logic [24:0] last;
        logic aw_h;
        logic [7:0] aw_a;
        logic w_h;
        logic [1:0] w_d;
        logic w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sbs_st_s;
endpackage

// ---- sbs_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to ref_clk
// Notes: level changes only once stages two and three agree
`timescale 1ns/1ps
module sbs_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sbs_sync_s;
    sbs_sync_s st_q;
    sbs_sync_s st_d;

    // stage one feeds two, two feeds three; level follows two and three once they agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.lvl = (st_q.s2 & st_q.s3) | (st_q.lvl & (st_q.s2 ^ st_q.s3));
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
endmodule

// ---- sbs_node.sv ----
// Purpose: slave logic of a powered two-wire sensor bus node
// Assumes: ref_clk 100 MHz, comparator and converter flags from analog blocks
// Notes: registers over AXI4-Lite; all state sits in one struct
// How it works
// - test indicator high only in test mode
// - filter under-voltage reset against short glitches
// - after reset answer nothing until initialised
// - frame threshold fall starts a new word
// - bit runs fall to fall, timing low/high
// - longer low means zero, longer high one
// - frame threshold rise ends the word
// - long frame-low time resets the node
// - bus-low timeout lies between 2 and 4 ms
// - bad checksum or length: only drops the pending answer and conversion
// - checksum x^4+1 seeded 1010, bitwise
// - one clock drives all logic and timing
// - LFSR bit stream dithers the oscillator
// - only request commands start a conversion
// - result goes out during next word
// - clamp results to 0020 through 03E3
// - conversion error reports 03F8
// - input pin one high forces 03F8
// - response current set at each bit start
// - response current off while bus idle
// - command opens or closes chain switches
// - clear, timeout or brown-out opens switches
// - only initialisation closes the switches
// - logic pins default to inputs
`timescale 1ns/1ps
`include "sbs_map.svh"
module sbs_node #(
    parameter logic [17:0] TIMEOUT_CYC = 18'(`SBS_TO_CYC),
    parameter logic [7:0] UV_CYC = 8'(`SBS_UVM_CYC)
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire sbs_pkg::sbs_axi_req_s axi_req,
    output sbs_pkg::sbs_axi_rsp_s axi_rsp,
    input wire logic frame_below,
    input wire logic signal_below,
    input wire logic hold_cap_low,
    input wire logic regulated_supply_low,
    input wire logic test_en,
    input wire logic [2:0] logic_pin_in,
    output logic [2:0] logic_pin_out,
    output logic [2:0] logic_pin_oe,
    output sbs_pkg::sbs_adc_req_s adc_req,
    input wire sbs_pkg::sbs_adc_rsp_s adc_rsp,
    output logic resp_current_on,
    output logic chain_switch,
    output logic test_indicator_out,
    output logic dither_out
);
    import sbs_pkg::*;

    sbs_st_s q;
    sbs_st_s d;
    logic [7:0] lvl;
    logic fr_low, sg_low, uv_any, tst_en, sg_fall, bit_val, in_bit;
    logic word_end, len_ok, word_ok, act_init, act_cmd, act_req;
    logic timeout_evt, uv_evt;
    logic [2:0] pin_lvl;
    logic [4:0] nb;
    logic [19:0] nsh;
    logic [3:0] w_addr, w_cmd;
    logic [7:0] w_data;
    logic [9:0] adc_val;
    logic [31:0] stat_word;

    // bitwise checksum over the first n-4 received bits
    function automatic logic [3:0] sbs_crc(input logic [19:0] w, input logic [4:0] n);
        logic [3:0] c;
        c = `SBS_CRC_SEED;
        for (int i = 19; i >= 4; i--) begin
            if (5'(i) < n) begin
                c = {c[2:0], c[3] ^ w[i]};
            end
        end
        return c;
    endfunction

    // response word: payload then its checksum
    function automatic logic [19:0] sbs_resp(input logic [15:0] p);
        return {p, sbs_crc({p, 4'h0}, `SBS_LEN_LONG)};
    endfunction

    // comparators, supply flags, test pin and logic pins
    sbs_sync #(.W(8)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({test_en, regulated_supply_low, hold_cap_low, signal_below,
            frame_below, logic_pin_in}),
        .level(lvl)
    );
    assign pin_lvl = lvl[2:0];
    assign fr_low = lvl[3];
    assign sg_low = lvl[4];
    assign uv_any = lvl[5] | lvl[6];
    assign tst_en = lvl[7];

    // bit decision and shift of the finished bit
    assign sg_fall = sg_low & ~q.sg_prev;
    assign bit_val = q.hi_cnt > q.lo_cnt;
    assign in_bit = (q.rx == rx_blo) || (q.rx == rx_bhi);
    assign nsh = in_bit ? {q.sh[18:0], bit_val} : q.sh;
    assign nb = (in_bit && q.bitcnt != `SBS_BITS_MAX) ? q.bitcnt + 5'h01 : q.bitcnt;

    // word checks and field split
    assign word_end = !fr_low && q.rx != rx_idle;
    assign len_ok = nb == `SBS_LEN_SHORT || nb == `SBS_LEN_LONG;
    assign word_ok = word_end && len_ok && sbs_crc(nsh, nb) == nsh[3:0];
    assign w_addr = nsh[11:8];
    assign w_cmd = nsh[7:4];
    assign w_data = (nb == `SBS_LEN_LONG) ? nsh[19:12] : 8'h00;
    assign act_init = word_ok && (!q.inited || !q.sw) && w_cmd == `SBS_CMD_INIT
        && w_addr == 4'h0; // re-init only while switches open
    assign act_cmd = word_ok && q.inited && w_addr == q.addr;
    assign act_req = act_cmd && (w_cmd == `SBS_CMD_REQ0 || w_cmd == `SBS_CMD_REQ1);

    // reset sources: bus-low timeout and filtered under-voltage
    assign timeout_evt = fr_low && q.to_cnt == TIMEOUT_CYC - 18'h1;
    assign uv_evt = uv_any && q.uv_cnt == UV_CYC - 8'h01;

    // reported conversion value
    always_comb begin
        if (adc_rsp.err || (!q.dir[1] && pin_lvl[1])) begin
            adc_val = `SBS_ADC_ERR;
        end else if (adc_rsp.code < `SBS_ADC_LO) begin
            adc_val = `SBS_ADC_LO;
        end else if (adc_rsp.code > `SBS_ADC_HI) begin
            adc_val = `SBS_ADC_HI;
        end else begin
            adc_val = adc_rsp.code;
        end
    end

    assign stat_word = {16'h0000, q.addr, 1'b0, q.dir, 1'b0, pin_lvl,
        q.test, q.sw, q.inited, q.pend_v};

    // next state of the whole node
    always_comb begin
        d = q;
        d.adc_start = 1'b0;
        d.sg_prev = sg_low;
        // dither stream from the same clock
        d.lfsr = {q.lfsr[14:0], ^(q.lfsr & `SBS_LFSR_TAPS)};
        d.dith = q.ctrl[1] & q.lfsr[15];
        // frame-low and under-voltage timers
        if (!fr_low) begin
            d.to_cnt = 18'h0;
        end else if (q.to_cnt != TIMEOUT_CYC) begin
            d.to_cnt = q.to_cnt + 18'h1;
        end
        if (!uv_any) begin
            d.uv_cnt = 8'h00;
        end else if (q.uv_cnt != UV_CYC) begin
            d.uv_cnt = q.uv_cnt + 8'h01;
        end
        // receiver and response transmitter
        case (q.rx)
            rx_idle: begin
                if (fr_low && q.to_cnt == 18'h0 && q.ctrl[0]) begin
                    d.rx = rx_wait;
                    d.bitcnt = 5'h00;
                    d.sh = 20'h00000;
                    d.tx = q.pend;
                    d.tx_v = q.pend_v && q.inited;
                    d.pend_v = 1'b0;
                end
            end
            default: begin
                if (!fr_low) begin
                    d.rx = rx_idle;
                    d.resp_on = 1'b0;
                    d.tx_v = 1'b0;
                end else if (sg_fall) begin
                    d.sh = nsh;
                    d.bitcnt = nb;
                    d.lo_cnt = 12'h001;
                    d.hi_cnt = 12'h000;
                    d.rx = rx_blo;
                    d.resp_on = q.tx_v & q.tx[19];
                    d.tx = {q.tx[18:0], 1'b0};
                end else if (q.rx == rx_blo) begin
                    if (sg_low) begin
                        if (q.lo_cnt != `SBS_CNT_MAX) d.lo_cnt = q.lo_cnt + 12'h001;
                    end else begin
                        d.rx = rx_bhi;
                        d.hi_cnt = 12'h001;
                    end
                end else if (q.rx == rx_bhi && q.hi_cnt != `SBS_CNT_MAX) begin
                    d.hi_cnt = q.hi_cnt + 12'h001;
                end
            end
        endcase
        // actions of a valid word
        if (word_ok) begin
            d.last = {nb, nsh};
        end
        if (act_init) begin
            d.inited = 1'b1;
            d.addr = w_data[3:0];
            d.sw = 1'b1;
        end
        if (act_cmd) begin
            case (w_cmd)
                `SBS_CMD_CLEAR: begin
                    d.sw = 1'b0;
                    d.dir = 3'h0;
                end
                `SBS_CMD_PINCTL: begin
                    d.dir = w_data[2:0];
                    d.oval = w_data[5:3];
                end
                `SBS_CMD_RDPIN: begin
                    d.pend = sbs_resp({13'h0000, pin_lvl});
                    d.pend_v = 1'b1;
                end
                `SBS_CMD_REQ0, `SBS_CMD_REQ1: begin
                    d.adc_start = 1'b1;
                    d.adc_chan = w_cmd == `SBS_CMD_REQ1;
                    d.adc_wait = 1'b1;
                end
                `SBS_CMD_TEST: begin
                    if (tst_en) d.test = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // finished conversion becomes the pending answer
        if (adc_rsp.done && q.adc_wait) begin
            d.pend = sbs_resp({adc_val, 6'h00});
            d.pend_v = 1'b1;
            d.adc_wait = 1'b0;
        end
        // a bad word drops whatever answer was pending
        if (word_end && !word_ok) begin
            d.pend_v = 1'b0;
            d.adc_wait = 1'b0;
        end
        if (!tst_en) begin
            d.test = 1'b0;
        end
        // node reset: uninitialised, switches open, pins inputs
        if (timeout_evt || uv_evt) begin
            d.inited = 1'b0;
            d.sw = 1'b0;
            d.dir = 3'h0;
            d.oval = 3'h0;
            d.test = 1'b0;
            d.pend_v = 1'b0;
            d.adc_wait = 1'b0;
            d.tx_v = 1'b0;
            d.resp_on = 1'b0;
        end
        // register bus: write address and data held separately
        if (axi_req.awvalid && !q.aw_h) begin
            d.aw_h = 1'b1;
            d.aw_a = axi_req.awaddr;
        end
        if (axi_req.wvalid && !q.w_h) begin
            d.w_h = 1'b1;
            d.w_d = axi_req.wdata[1:0];
            d.w_s = axi_req.wstrb[0];
        end
        if (q.aw_h && q.w_h && !q.bvalid) begin
            d.aw_h = 1'b0;
            d.w_h = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `SBS_RESP_OK;
            if (q.aw_a == `SBS_OFS_CTRL) begin
                if (q.w_s) d.ctrl = q.w_d;
            end else if (q.aw_a != `SBS_OFS_STAT && q.aw_a != `SBS_OFS_LAST) begin
                d.bresp = `SBS_RESP_ERR;
            end
        end else if (q.bvalid && axi_req.bready) begin
            d.bvalid = 1'b0;
        end
        // register bus: read
        if (axi_req.arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = `SBS_RESP_OK;
            case (axi_req.araddr)
                `SBS_OFS_CTRL: d.rdata = {30'h00000000, q.ctrl};
                `SBS_OFS_STAT: d.rdata = stat_word;
                `SBS_OFS_LAST: d.rdata = {7'h00, q.last};
                default: begin
                    d.rdata = 32'h00000000;
                    d.rresp = `SBS_RESP_ERR;
                end
            endcase
        end else if (q.rvalid && axi_req.rready) begin
            d.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{rx: rx_idle, ctrl: `SBS_CTRL_RST, lfsr: `SBS_LFSR_SEED, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs
    assign axi_rsp = '{awready: !q.aw_h, wready: !q.w_h, bvalid: q.bvalid, bresp: q.bresp,
        arready: !q.rvalid, rvalid: q.rvalid, rdata: q.rdata, rresp: q.rresp};
    assign adc_req = '{start: q.adc_start, chan: q.adc_chan};
    assign resp_current_on = q.resp_on;
    assign chain_switch = q.sw;
    assign test_indicator_out = q.test;
    assign dither_out = q.dith;
    assign logic_pin_out = q.oval;
    assign logic_pin_oe = q.dir;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_test_low; !tst_en |=> !test_indicator_out; endproperty
    a_test_low: assert property (p_test_low) else $error("test indicator high");
    property p_uv_glitch; $rose(uv_any) |-> !uv_evt [*8]; endproperty
    a_uv_glitch: assert property (p_uv_glitch) else $error("unfiltered reset");
    property p_uninit_quiet; !q.inited |-> !resp_current_on; endproperty
    a_uninit_quiet: assert property (p_uninit_quiet) else $error("answer uninit");
    property p_timeout; timeout_evt |=> !chain_switch && !q.inited; endproperty
    a_timeout: assert property (p_timeout) else $error("timeout no reset");
    property p_bad_word; word_end && !word_ok |=> !q.pend_v && !q.adc_wait; endproperty
    a_bad_word: assert property (p_bad_word) else $error("bad word acted");
    property p_conv_start; adc_req.start |-> $past(act_req); endproperty
    a_conv_start: assert property (p_conv_start) else $error("stray conversion");
    property p_clamp;
        adc_rsp.done && q.adc_wait |=> (q.pend[19:10] >= `SBS_ADC_LO &&
            q.pend[19:10] <= `SBS_ADC_HI) || q.pend[19:10] == `SBS_ADC_ERR;
    endproperty
    a_clamp: assert property (p_clamp) else $error("value out of range");
    property p_pin_err;
        adc_rsp.done && q.adc_wait && !q.dir[1] && pin_lvl[1] |=> q.pend[19:10] == `SBS_ADC_ERR;
    endproperty
    a_pin_err: assert property (p_pin_err) else $error("pin one error lost");
    property p_bit_start;
        q.rx != rx_idle && fr_low && sg_fall && !timeout_evt && !uv_evt |=>
            resp_current_on == $past(q.tx_v & q.tx[19]);
    endproperty
    a_bit_start: assert property (p_bit_start) else $error("wrong response bit");
    property p_idle_off; q.rx == rx_idle |-> !resp_current_on; endproperty
    a_idle_off: assert property (p_idle_off) else $error("current on in idle");
    property p_close; $rose(chain_switch) |-> $past(act_init); endproperty
    a_close: assert property (p_close) else $error("switch closed without init");
endmodule

// ---- sbs_bus_master.sv ----
// Purpose: bus master stand-in driving frame and signal levels
// Assumes: levels high while the bus sits below a threshold
// Notes: 60-cycle bits, answer sampled in the low phase
`timescale 1ns/1ps
module sbs_bus_master (
    input wire logic ref_clk,
    input wire logic resp_in,
    output logic frame_below,
    output logic signal_below
);
    // idle bus sits above both thresholds
    initial begin
        frame_below = 1'b0;
        signal_below = 1'b0;
    end
    // one word, msb first, checksum appended, last bit flipped on bad
    task automatic send(input logic [15:0] w, input int n, input logic bad,
                        output logic [19:0] ans);
        logic [3:0] c;
        logic b;
        int lo;
        c = 4'hA;
        ans = '0;
        frame_below <= 1'b1;
        repeat (12) @(posedge ref_clk);
        for (int i = 0; i < n + 4; i++) begin
            if (i < n) begin
                b = w[n-1-i];
                c = {c[2:0], c[3] ^ b};
            end else begin
                b = c[n+3-i] ^ (bad && i == n + 3);
            end
            lo = b ? 20 : 40;
            signal_below <= 1'b1;
            repeat (15) @(posedge ref_clk);
            ans = {ans[18:0], resp_in};
            repeat (lo - 15) @(posedge ref_clk);
            signal_below <= 1'b0;
            repeat (60 - lo) @(posedge ref_clk);
        end
        frame_below <= 1'b0;
        repeat (30) @(posedge ref_clk);
    endtask
    // frame level held down with no bits
    task automatic hold(input int n);
        frame_below <= 1'b1;
        repeat (n) @(posedge ref_clk);
        frame_below <= 1'b0;
        repeat (30) @(posedge ref_clk);
    endtask
endmodule

// ---- testbench.sv ----
// Purpose: self-checking bench for the sensor bus node
// Assumes: timeout shortened to 2000 cycles, brown-out mask 20
// Notes: converter stand-in answers ten cycles after start
`timescale 1ns/1ps
`include "sbs_map.svh"
module testbench;
    import sbs_pkg::*;
    logic ref_clk;
    logic nrst;
    logic hold_cap_low;
    logic regulated_supply_low;
    logic test_en;
    logic [2:0] logic_pin_in;
    logic [2:0] logic_pin_out;
    logic [2:0] logic_pin_oe;
    sbs_axi_req_s req;
    sbs_axi_rsp_s rsp;
    sbs_adc_req_s adc_req;
    sbs_adc_rsp_s adc_rsp;
    logic frame_below;
    logic signal_below;
    logic resp_current_on;
    logic chain_switch;
    logic test_indicator_out;
    logic dither_out;
    logic dith_prev;
    logic [9:0] adc_val;
    logic adc_e;
    logic [3:0] adc_cnt;
    logic [19:0] ans;
    logic [31:0] rd;
    int miscompares;
    int checked;
    int starts;
    int toggles;
    sbs_node #(.TIMEOUT_CYC(18'h007D0), .UV_CYC(8'h14)) u_sbs_node (.ref_clk(ref_clk),
        .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .frame_below(frame_below),
        .signal_below(signal_below), .hold_cap_low(hold_cap_low),
        .regulated_supply_low(regulated_supply_low), .test_en(test_en),
        .logic_pin_in(logic_pin_in), .logic_pin_out(logic_pin_out),
        .logic_pin_oe(logic_pin_oe), .adc_req(adc_req), .adc_rsp(adc_rsp),
        .resp_current_on(resp_current_on), .chain_switch(chain_switch),
        .test_indicator_out(test_indicator_out), .dither_out(dither_out));
    sbs_bus_master u_sbs_bus_master (.ref_clk(ref_clk), .resp_in(resp_current_on),
        .frame_below(frame_below), .signal_below(signal_below));
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // converter stand-in and activity counters
    always @(posedge ref_clk) begin
        adc_rsp.done <= 1'b0;
        if (dither_out !== dith_prev) toggles++;
        dith_prev <= dither_out;
        if (adc_req.start === 1'b1) begin
            starts++;
            adc_cnt <= 4'hA;
        end else if (adc_cnt == 4'h1) begin
            adc_rsp <= {1'b1, adc_e, adc_val};
            adc_cnt <= 4'h0;
        end else if (adc_cnt != 4'h0) begin
            adc_cnt <= adc_cnt - 4'h1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge ref_clk);
            if (!aw && rsp.awready === 1'b1) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready === 1'b1) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (rsp.bvalid !== 1'b1);
        chk(rsp.bresp, er, "bresp");
        req.bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge ref_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        chk(rsp.rresp, er, "rresp");
        req.rready <= 1'b0;
    endtask
    task automatic word(input logic [7:0] d, input logic [3:0] a, input logic [3:0] c);
        u_sbs_bus_master.send({d, a, c}, 16, 1'b0, ans);
    endtask
    task automatic t_regs;
        int s;
        axi_rd(`SBS_OFS_CTRL, rd, `SBS_RESP_OK);
        chk(rd, 32'h3, "ctrl reset");
        axi_wr(8'h0C, 32'h1, `SBS_RESP_ERR);
        axi_rd(8'h0C, rd, `SBS_RESP_ERR);
        chk(rd, 32'h0, "unmapped");
        axi_wr(`SBS_OFS_CTRL, 32'h0, `SBS_RESP_OK);
        repeat (2) @(posedge ref_clk);
        s = toggles;
        repeat (20) @(posedge ref_clk);
        chk(toggles - s, 0, "dither off");
        axi_rd(`SBS_OFS_CTRL, rd, `SBS_RESP_OK);
        chk(rd, 32'h0, "ctrl written");
        axi_wr(`SBS_OFS_CTRL, 32'h3, `SBS_RESP_OK);
        chk({chain_switch, test_indicator_out, resp_current_on, logic_pin_oe}, 0, "idle");
        $display("t_regs done");
    endtask
    task automatic t_init;
        word(8'h00, 4'h0, `SBS_CMD_RDPIN);
        word(8'h05, 4'h0, `SBS_CMD_INIT);
        chk(ans, 0, "no answer before init");
        chk(chain_switch, 1, "init closes");
        chk(resp_current_on, 0, "idle current");
        axi_rd(`SBS_OFS_STAT, rd, `SBS_RESP_OK);
        chk({rd[15:12], rd[2:1]}, 6'h17, "status");
        $display("t_init done");
    endtask
    task automatic t_pins;
        logic_pin_in <= 3'b101;
        word(8'h00, 4'h5, `SBS_CMD_RDPIN);
        word(8'h1D, 4'h5, `SBS_CMD_PINCTL);
        chk(ans[19:4], 16'h0005, "pin answer");
        chk({logic_pin_oe, logic_pin_out & logic_pin_oe}, 6'h29, "pin ctl");
        $display("t_pins done");
    endtask
    task automatic t_adc;
        logic [9:0] raw [6];
        logic [9:0] exp [6];
        int s;
        raw = '{10'h010, 10'h3F0, 10'h200, 10'h155, 10'h200, 10'h201};
        exp = '{10'h020, 10'h3E3, 10'h200, 10'h3F8, 10'h3F8, 10'h201};
        for (int i = 0; i < 6; i++) begin
            adc_val <= raw[i];
            adc_e <= (i == 3);
            logic_pin_in <= (i >= 4) ? 3'b010 : 3'b000;
            if (i == 5) word(8'h12, 4'h5, `SBS_CMD_PINCTL);
            s = starts;
            word(8'h00, 4'h5, i[0] ? `SBS_CMD_REQ1 : `SBS_CMD_REQ0);
            chk(adc_req.chan, i[0], "channel");
            word(8'h00, 4'h5, `SBS_CMD_RDPIN);
            chk(ans[19:4], {exp[i], 6'h00}, "conversion");
            chk(starts - s, 1, "one start");
        end
        $display("t_adc done");
    endtask
    task automatic t_errs;
        u_sbs_bus_master.send({8'h00, 4'h5, `SBS_CMD_CLEAR}, 16, 1'b1, ans);
        chk(chain_switch, 1, "bad checksum");
        u_sbs_bus_master.send({8'h00, 4'h5, `SBS_CMD_CLEAR}, 15, 1'b0, ans);
        chk(chain_switch, 1, "bad length");
        word(8'h00, 4'h5, `SBS_CMD_CLEAR);
        chk({chain_switch, logic_pin_oe}, 0, "clear");
        test_en <= 1'b0;
        word(8'h00, 4'h5, `SBS_CMD_TEST);
        chk(test_indicator_out, 0, "test refused");
        test_en <= 1'b1;
        word(8'h05, 4'h0, `SBS_CMD_INIT);
        word(8'h00, 4'h5, `SBS_CMD_TEST);
        chk({chain_switch, test_indicator_out}, 2'h3, "reinit and test");
        $display("t_errs done");
    endtask
    task automatic t_resets;
        u_sbs_bus_master.hold(1500);
        chk(chain_switch, 1, "short low");
        u_sbs_bus_master.hold(2600);
        chk({chain_switch, test_indicator_out}, 0, "timeout");
        axi_rd(`SBS_OFS_STAT, rd, `SBS_RESP_OK);
        chk(rd[1], 0, "uninit after timeout");
        word(8'h05, 4'h0, `SBS_CMD_INIT);
        hold_cap_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        hold_cap_low <= 1'b0;
        repeat (40) @(posedge ref_clk);
        chk(chain_switch, 1, "glitch filtered");
        regulated_supply_low <= 1'b1;
        repeat (60) @(posedge ref_clk);
        regulated_supply_low <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk(chain_switch, 0, "brown-out");
        chk(toggles != 0, 1, "dither runs");
        $display("t_resets done");
    endtask
    // main sequence
    initial begin
        {nrst, hold_cap_low, regulated_supply_low, test_en, logic_pin_in} = '0;
        {req, adc_rsp, adc_val, adc_e, adc_cnt, dith_prev} = '0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_regs();
        t_init();
        t_pins();
        t_adc();
        t_errs();
        t_resets();
        wrap_up();
    end
    // watchdog
    initial begin
        #900000;
        miscompares++;
        wrap_up();
    end
endmodule
